// *** common/digital_loop_pkg.sv ***
// Purpose: Shared constants for the digital phase-locked-loop core
// Assumes: One system clock at 100 MHz; all loop signals arrive as pins
// Notes: Loop counter modulus is 2**(select + LEN_OFFSET)
package digital_loop_pkg;
    localparam int CLK_MHZ = 100;          // System clock rate
    localparam int SEL_W = 4;              // Length-select width
    localparam int CNT_W = 17;             // Longest loop counter, stages
    localparam int LEN_OFFSET = 2;         // Stages above the select value
    localparam int SYNC_W = 9;             // Pin inputs passed through synchronisers
    localparam int ADJ_W = 2;              // Width of the adjust counter
    localparam logic [ADJ_W-1:0] ADJ_EDGES = 2'h2; // Toggles per added or deleted pulse
    localparam logic [CNT_W-1:0] CNT_RESET = 17'h00000;
    localparam logic [SEL_W-1:0] SEL_INHIBIT = 4'h0;
    // Bit positions inside the synchroniser vector
    localparam int PIN_SEL = 0;            // Four bits from here
    localparam int PIN_LOOP_CLK = 4;
    localparam int PIN_INCDEC_CLK = 5;
    localparam int PIN_XOR_FIRST = 6;
    localparam int PIN_EDGE_FIRST = 7;
    localparam int PIN_SHARED = 8;
    typedef enum logic [2:0] {
        ADJ_IDLE = 3'b001,
        ADJ_INSERT = 3'b010,
        ADJ_DELETE = 3'b100
    } adj_state_e;
endpackage

// *** common/loop_if.sv ***
// Purpose: Carries carry/borrow requests and clock events to the output stage
// Assumes: Both ends run on the same system clock
// Notes: Requests stay high until the matching take pulse
`timescale 1ns/10ps
interface loop_if;
    logic carry_req;
    logic borrow_req;
    logic take_carry;
    logic take_borrow;
    logic id_rise;
    logic id_fall;
    modport counter_end (
        output carry_req,
        output borrow_req,
        output id_rise,
        output id_fall,
        input take_carry,
        input take_borrow
    );
    modport output_end (
        input carry_req,
        input borrow_req,
        input id_rise,
        input id_fall,
        output take_carry,
        output take_borrow
    );
endinterface

// *** core/incdec_unit.sv ***
// Purpose: Increment/decrement stage dividing its clock by two
// Assumes: Clock events are one-cycle pulses from synchronised pins
// Notes: One added pulse is two extra toggles on falling clock edges
`timescale 1ns/10ps
module incdec_unit
    import digital_loop_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    loop_if.output_end lp,
    output logic incdec_out_o
);

    adj_state_e state_q;
    logic [ADJ_W-1:0] left_q;

    ////////////////////////////////////////////////////////////////////
    // Adjust sequencer and output toggle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= ADJ_IDLE;
            left_q <= '0;
            incdec_out_o <= 1'b0; // [R19]
            lp.take_carry <= 1'b0;
            lp.take_borrow <= 1'b0;
        end else begin
            lp.take_carry <= 1'b0;
            lp.take_borrow <= 1'b0;
            case (state_q)
                ADJ_IDLE: begin
                    // Half of the input clock when nothing arrives
                    if (lp.id_rise) begin
                        incdec_out_o <= ~incdec_out_o; // [R12]
                    end
                    if (lp.carry_req) begin
                        lp.take_carry <= 1'b1; // [R20]
                        state_q <= ADJ_INSERT;
                        left_q <= ADJ_EDGES;
                    end else if (lp.borrow_req) begin
                        lp.take_borrow <= 1'b1; // [R20]
                        state_q <= ADJ_DELETE;
                        left_q <= ADJ_EDGES;
                    end
                end
                ADJ_INSERT: begin
                    // Extra toggles on falling edges add one pulse
                    if (lp.id_rise || lp.id_fall) begin
                        incdec_out_o <= ~incdec_out_o; // [R13]
                    end
                    if (lp.id_fall) begin
                        left_q <= left_q - 2'h1;
                        if (left_q == 2'h1) begin
                            state_q <= ADJ_IDLE;
                        end
                    end
                end
                ADJ_DELETE: begin
                    // Skipped toggles on rising edges remove one pulse
                    if (lp.id_rise) begin
                        left_q <= left_q - 2'h1; // [R13]
                        if (left_q == 2'h1) begin
                            state_q <= ADJ_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ADJ_IDLE;
                    left_q <= '0;
                end
            endcase
        end
    end

endmodule

// *** core/digital_pll_core.sv ***
// Purpose: First-order digital loop core: detectors, loop counter, output stage
// Assumes: All pins are asynchronous to clk_i and slow against 100 MHz
// Notes: Loop and output-stage clocks are sampled pins used as edge events
// Notes: Carry and borrow stand for one loop-clock period each
//
// Function
// R1 - All selects low inhibits the loop counter
// R2 - Select one gives a three-stage counter
// R3 - All selects high gives seventeen stages
// R4 - Modulus is two to the select plus two
// R5 - Selects may change while running
// R6 - Xor detector high when its inputs differ
// R7 - Edge detector: shared fall sets, first fall clears
// R8 - Chosen detector sets the count direction
// R9 - Counter advances only on loop-counter clock
// R10 - Upward wrap gives one carry pulse
// R11 - Downward wrap gives one borrow pulse
// R12 - Idle output stage halves its clock
// R13 - Carry adds a pulse, borrow deletes one
// R14 - Output-stage clock runs at 2N center
// R15 - Xor detector inputs need 50% duty
// R16 - Xor zero error: quarter cycle, square output
// R17 - Edge zero error: half cycle, square output
// R18 - Outside divider closes the loop
// R19 - Reset clears counter and output toggle
// R20 - Pulses last one loop clock, crossed safely
`timescale 1ns/10ps
module digital_pll_core
    import digital_loop_pkg::*;
#(
    parameter int LEN_W = CNT_W
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic loop_clk_i,
    input wire logic incdec_clock_i,
    input wire logic xor_in_first_i,
    input wire logic edge_in_first_i,
    input wire logic shared_phase_i,
    input wire logic [SEL_W-1:0] length_sel_i,
    input wire logic det_sel_i,
    output logic xor_detector_out_o,
    output logic edge_detector_out_o,
    output logic carry_o,
    output logic borrow_o,
    output logic incdec_out_o
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] prev_q;
    logic det_sel_meta_q;
    logic det_sel_q;
    logic [SEL_W-1:0] sel;
    logic loop_rise;
    logic shared_fall;
    logic edge_first_fall;
    logic count_up;
    logic [SEL_W:0] shift_amt;
    logic [LEN_W:0] span;
    logic [LEN_W-1:0] top;
    logic [LEN_W-1:0] cnt_q;
    logic wrap_up;
    logic wrap_down;
    logic carry_pend_q;
    logic borrow_pend_q;
    logic rise_q;
    logic fall_q;

    // Link to the output stage
    loop_if lp ();

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops per bit
    assign pins = {shared_phase_i, edge_in_first_i, xor_in_first_i,
                   incdec_clock_i, loop_clk_i, length_sel_i};

    generate
        for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                    prev_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= pins[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end
        end
    endgenerate

    // Detector choice is a pin as well
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            det_sel_meta_q <= 1'b0;
            det_sel_q <= 1'b0;
        end else begin
            det_sel_meta_q <= det_sel_i;
            det_sel_q <= det_sel_meta_q;
        end
    end

    // Edge events from the synchronised copies only
    assign sel = sync_q[PIN_SEL +: SEL_W];
    assign loop_rise = sync_q[PIN_LOOP_CLK] & ~prev_q[PIN_LOOP_CLK];
    assign shared_fall = ~sync_q[PIN_SHARED] & prev_q[PIN_SHARED];
    assign edge_first_fall = ~sync_q[PIN_EDGE_FIRST] & prev_q[PIN_EDGE_FIRST];

    ////////////////////////////////////////////////////////////////////
    // Phase detectors
    // Xor detector: inputs differ gives high; square at quarter-cycle offset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            xor_detector_out_o <= 1'b0;
        end else begin
            xor_detector_out_o <= sync_q[PIN_XOR_FIRST] ^ sync_q[PIN_SHARED]; // [R6] [R16]
        end
    end

    // Edge detector: falling edges only; shared input wins a tie
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            edge_detector_out_o <= 1'b0;
        end else if (shared_fall) begin
            edge_detector_out_o <= 1'b1; // [R7] [R17]
        end else if (edge_first_fall) begin
            edge_detector_out_o <= 1'b0; // [R7]
        end
    end

    // Selected detector high counts up
    assign count_up = det_sel_q ? edge_detector_out_o : xor_detector_out_o; // [R8]

    ////////////////////////////////////////////////////////////////////
    // Loop counter modulus from the live select value
    // Shift needs a fifth bit: select 15 plus two is 17
    assign shift_amt = {1'b0, sel} + (SEL_W + 1)'(LEN_OFFSET);
    assign span = (LEN_W + 1)'(1) << shift_amt; // [R4] [R5]
    assign top = LEN_W'(span - (LEN_W + 1)'(1));             // [R2] [R3]

    // Wrap detection; a shrunk modulus wraps at the next upward count
    assign wrap_up = loop_rise && (sel != SEL_INHIBIT) && count_up && (cnt_q >= top);
    assign wrap_down = loop_rise && (sel != SEL_INHIBIT) && !count_up && (cnt_q == '0);

    // Counter advances only on loop-counter clock edges
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= LEN_W'(CNT_RESET); // [R19]
        end else if (sel == SEL_INHIBIT) begin
            cnt_q <= LEN_W'(CNT_RESET); // [R1]
        end else if (loop_rise) begin // [R9]
            if (count_up) begin
                cnt_q <= wrap_up ? '0 : cnt_q + LEN_W'(1);
            end else begin
                cnt_q <= wrap_down ? top : cnt_q - LEN_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Carry and borrow outputs, one loop-clock period each
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            carry_o <= 1'b0;
            borrow_o <= 1'b0;
        end else if (loop_rise) begin
            carry_o <= wrap_up;    // [R10] [R20]
            borrow_o <= wrap_down; // [R11] [R20]
        end
    end

    // Pending requests to the output stage; a new wrap beats the take
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            carry_pend_q <= 1'b0;
            borrow_pend_q <= 1'b0;
        end else begin
            if (wrap_up) begin
                carry_pend_q <= 1'b1; // [R20]
            end else if (lp.take_carry) begin
                carry_pend_q <= 1'b0;
            end
            if (wrap_down) begin
                borrow_pend_q <= 1'b1; // [R20]
            end else if (lp.take_borrow) begin
                borrow_pend_q <= 1'b0;
            end
        end
    end

    // Output-stage clock events, registered once
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= sync_q[PIN_INCDEC_CLK] & ~prev_q[PIN_INCDEC_CLK];
            fall_q <= ~sync_q[PIN_INCDEC_CLK] & prev_q[PIN_INCDEC_CLK];
        end
    end

    // Requests and clock events towards the output stage
    assign lp.carry_req = carry_pend_q;
    assign lp.borrow_req = borrow_pend_q;
    assign lp.id_rise = rise_q;
    assign lp.id_fall = fall_q;

    ////////////////////////////////////////////////////////////////////
    // Increment/decrement output stage
    incdec_unit incdec_unit_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .lp(lp.output_end),
        .incdec_out_o(incdec_out_o)
    );

endmodule

// *** verif/digital_pll_core_assertions.sv ***
// Purpose: Port-level checks of the loop core
// Assumes: Pins move just after clk_i rises
// Notes: Pin to output latency is three edges, four for incdec_out_o
`timescale 1ns/10ps
module digital_pll_core_assertions
    import digital_loop_pkg::*;
#(
    parameter int LEN_W = CNT_W
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic loop_clk_i,
    input wire logic incdec_clock_i,
    input wire logic xor_in_first_i,
    input wire logic edge_in_first_i,
    input wire logic shared_phase_i,
    input wire logic [SEL_W-1:0] length_sel_i,
    input wire logic det_sel_i,
    input wire logic xor_detector_out_o,
    input wire logic edge_detector_out_o,
    input wire logic carry_o,
    input wire logic borrow_o,
    input wire logic incdec_out_o
);
    logic xr;
    logic dir;
    // Raw xor of pins and the chosen direction
    assign xr = xor_in_first_i ^ shared_phase_i;
    assign dir = det_sel_i ? edge_detector_out_o : xor_detector_out_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    property p_xor;
        $past(rst_n_i, 3) |-> xor_detector_out_o == $past(xr, 3);
    endproperty
    a_xor: assert property (p_xor) else $error("xor out wrong");
    property p_eset;
        $fell(shared_phase_i) |-> ##3 edge_detector_out_o;
    endproperty
    a_eset: assert property (p_eset) else $error("edge out not set");
    property p_eclr;
        $fell(edge_in_first_i) && !$fell(shared_phase_i) |-> ##3 !edge_detector_out_o;
    endproperty
    a_eclr: assert property (p_eclr) else $error("edge out not cleared");
    property p_inh;
        $rose(loop_clk_i) && length_sel_i == SEL_INHIBIT |-> ##6 !carry_o && !borrow_o;
    endproperty
    a_inh: assert property (p_inh) else $error("pulse while inhibited");
    property p_excl;
        !(carry_o && borrow_o);
    endproperty
    a_excl: assert property (p_excl) else $error("carry and borrow together");
    property p_kclk;
        $changed(carry_o) || $changed(borrow_o) |-> $past(loop_clk_i, 2) || $past(loop_clk_i, 3);
    endproperty
    a_kclk: assert property (p_kclk) else $error("pulse off loop clock");
    property p_up;
        $rose(carry_o) |-> $past(dir, 1) || $past(dir, 2);
    endproperty
    a_up: assert property (p_up) else $error("carry while counting down");
    property p_dn;
        $rose(borrow_o) |-> !$past(dir, 1) || !$past(dir, 2);
    endproperty
    a_dn: assert property (p_dn) else $error("borrow while counting up");
    property p_tog;
        $changed(incdec_out_o) |-> $past(incdec_clock_i, 3) != $past(incdec_clock_i, 6);
    endproperty
    a_tog: assert property (p_tog) else $error("output toggle off clock");
endmodule
bind digital_pll_core digital_pll_core_assertions #(.LEN_W(LEN_W)) digital_pll_core_assertions_i (
    .clk_i, .rst_n_i, .loop_clk_i, .incdec_clock_i, .xor_in_first_i, .edge_in_first_i,
    .shared_phase_i, .length_sel_i, .det_sel_i, .xor_detector_out_o, .edge_detector_out_o,
    .carry_o, .borrow_o, .incdec_out_o);

// *** verif/loop_partner.sv ***
// Purpose: Reference clock source and outside divider
// Assumes: Clock edges offset from clk_i edges
// Notes: Half period HP in 10 ns steps
`timescale 1ns/10ps
module loop_partner #(
    parameter int N = 4,
    parameter int HP = 8
)
(
    input wire logic out_i,
    output logic idc_o,
    output logic div_o
);
    int cnt;
    // Output-stage clock at 2N times the center rate
    initial begin
        idc_o = 1'b0;
        #6;
        forever #(HP * 10) idc_o = ~idc_o;
    end
    // Divide by N with even duty, fed back to the detectors
    initial begin
        div_o = 1'b0;
        cnt = 0;
        forever begin
            @(posedge out_i);
            cnt++;
            if (cnt == N / 2) begin
                cnt = 0;
                div_o <= ~div_o;
            end
        end
    end
endmodule

// *** verif/digital_pll_core_tb.sv ***
// Purpose: Self-checking bench of the loop core
// Assumes: Inputs move 1 ns after clk_i rises
// Notes: Toggle counts span eight output-stage clock periods
`timescale 1ns/10ps
module digital_pll_core_tb
    import digital_loop_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic kclk = 1'b0;
    logic xa = 1'b0;
    logic ea = 1'b0;
    logic sh = 1'b0;
    logic use_div = 1'b0;
    logic dsel = 1'b0;
    logic [SEL_W-1:0] sel = 4'h0;
    logic idc, div, shared, xo, eo, cy, bw, ido;
    int num_errors = 0;
    int n_checks = 0;
    // Shared phase from bench or from the divider
    assign shared = use_div ? div : sh;
    // Clock at 100 MHz
    always #5 clk_i = ~clk_i;
    loop_partner loop_partner_i (.out_i(ido), .idc_o(idc), .div_o(div));
    digital_pll_core digital_pll_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .loop_clk_i(kclk), .incdec_clock_i(idc), .xor_in_first_i(xa), .edge_in_first_i(ea),
        .shared_phase_i(shared), .length_sel_i(sel), .det_sel_i(dsel),
        .xor_detector_out_o(xo), .edge_detector_out_o(eo), .carry_o(cy), .borrow_o(bw),
        .incdec_out_o(ido));
    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, s, got, exp);
        end
    endtask
    task automatic kp(input int n);
        repeat (n) begin
            kclk = 1'b1;
            cyc(4);
            kclk = 1'b0;
            cyc(4);
        end
    endtask
    // One loop rise, then count output toggles
    task automatic adj(input logic up, input logic [7:0] exp);
        logic p;
        logic [7:0] tog;
        xa = up;
        // Let earlier adjusts finish before counting
        cyc(96);
        kclk = 1'b1;
        tog = 8'h00;
        p = ido;
        repeat (128) begin
            cyc(1);
            if (ido !== p) tog++;
            p = ido;
        end
        kclk = 1'b0;
        cyc(6);
        chk(tog, exp, "toggles");
    endtask
    task automatic t_det;
        for (int i = 0; i < 4; i++) begin
            xa = i[0];
            sh = i[1];
            cyc(5);
            chk(xo, i[0] ^ i[1], "xor");
        end
        chk(eo, 1'b0, "edge rise");
        sh = 1'b0;
        cyc(5);
        chk(eo, 1'b1, "edge set");
        ea = 1'b1;
        cyc(5);
        chk(eo, 1'b1, "edge hold");
        ea = 1'b0;
        cyc(5);
        chk(eo, 1'b0, "edge clear");
        ea = 1'b1;
        sh = 1'b1;
        cyc(5);
        ea = 1'b0;
        sh = 1'b0;
        cyc(5);
        chk(eo, 1'b1, "edge both");
        ea = 1'b1;
        cyc(5);
        ea = 1'b0;
        cyc(5);
        $display("t_det done");
    endtask
    task automatic t_cnt;
        xa = 1'b1;
        kp(8);
        chk({cy, bw}, 2'b00, "inhibit");
        adj(1'b1, 8'h08);
        sel = 4'h1;
        kp(7);
        chk(cy, 1'b0, "early");
        kp(1);
        chk(cy, 1'b1, "wrap 8");
        kp(1);
        chk(cy, 1'b0, "refresh");
        sel = 4'h2;
        kp(14);
        chk(cy, 1'b0, "early 16");
        kp(1);
        chk(cy, 1'b1, "wrap 16");
        xa = 1'b0;
        cyc(6);
        kp(1);
        chk(bw, 1'b1, "down wrap");
        sel = 4'hf;
        xa = 1'b1;
        cyc(6);
        kp(2);
        chk(cy, 1'b0, "long");
        sel = 4'h1;
        adj(1'b1, 8'h0a);
        adj(1'b0, 8'h06);
        $display("t_cnt done");
    endtask
    task automatic t_loop;
        logic p;
        int i;
        dsel = 1'b1;
        ea = 1'b1;
        use_div = 1'b1;
        p = div;
        i = 0;
        while (!(p === 1'b1 && div === 1'b0) && i < 300) begin
            p = div;
            cyc(1);
            i++;
        end
        chk(8'(i < 300), 8'h01, "divider fall seen");
        cyc(5);
        chk(eo, 1'b1, "divider fall");
        kp(1);
        chk(cy, 1'b1, "edge up");
        $display("t_loop done");
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        cyc(6);
        rst_n_i = 1'b1;
        cyc(2);
        t_det;
        t_cnt;
        t_loop;
        test_done;
    end
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        test_done;
    end
endmodule
